// ---- verilog/ptsc_pkg.sv ----
// Shared constants and types for one port's transmit statistics counter set.
// Assumes a single system clock and a transmit MAC that reports each
// completed frame with a one-cycle valid and its length, broadcast and
// collision status.
package ptsc_pkg;

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    // Base register numbers of the counter set for each port.
    localparam logic [11:0] BASE_PORT0 = 12'h0454;
    localparam logic [11:0] BASE_PORT1 = 12'h0854;
    localparam logic [11:0] BASE_PORT2 = 12'h0C54;

    // Port 0 register numbers; other ports keep the same relative layout.
    localparam logic [11:0] REG_TX_EXACT_MIN  = 12'h0454;
    localparam logic [11:0] REG_TX_SMALL_BIN  = 12'h0455;
    localparam logic [11:0] REG_TX_MED_SMALL  = 12'h0456;
    localparam logic [11:0] REG_TX_MEDIUM     = 12'h0457;
    localparam logic [11:0] REG_TX_MED_LARGE  = 12'h0458;
    localparam logic [11:0] REG_TX_LARGE_BIN  = 12'h0459;
    localparam logic [11:0] REG_TX_RUNT       = 12'h045A;
    localparam logic [11:0] REG_TX_BYTE_TOTAL = 12'h045C;
    localparam logic [11:0] REG_TX_BROADCAST  = 12'h045D;

    // Offsets relative to the port base.
    localparam logic [11:0] REL_TX_EXACT_MIN  = REG_TX_EXACT_MIN - BASE_PORT0;
    localparam logic [11:0] REL_TX_SMALL_BIN  = REG_TX_SMALL_BIN - BASE_PORT0;
    localparam logic [11:0] REL_TX_MED_SMALL  = REG_TX_MED_SMALL - BASE_PORT0;
    localparam logic [11:0] REL_TX_MEDIUM     = REG_TX_MEDIUM - BASE_PORT0;
    localparam logic [11:0] REL_TX_MED_LARGE  = REG_TX_MED_LARGE - BASE_PORT0;
    localparam logic [11:0] REL_TX_LARGE_BIN  = REG_TX_LARGE_BIN - BASE_PORT0;
    localparam logic [11:0] REL_TX_RUNT       = REG_TX_RUNT - BASE_PORT0;
    localparam logic [11:0] REL_TX_BYTE_TOTAL = REG_TX_BYTE_TOTAL - BASE_PORT0;
    localparam logic [11:0] REL_TX_BROADCAST  = REG_TX_BROADCAST - BASE_PORT0;

    // ------------------------------------------------------------------
    // Counter slots and values
    // ------------------------------------------------------------------
    localparam int          NUM_CNT   = 9;
    localparam logic [3:0]  SLOT_64   = 4'h0;
    localparam logic [3:0]  SLOT_65   = 4'h1;
    localparam logic [3:0]  SLOT_128  = 4'h2;
    localparam logic [3:0]  SLOT_256  = 4'h3;
    localparam logic [3:0]  SLOT_512  = 4'h4;
    localparam logic [3:0]  SLOT_1024 = 4'h5;
    localparam logic [3:0]  SLOT_RUNT = 4'h6;
    localparam logic [3:0]  SLOT_BYTE = 4'h7;
    localparam logic [3:0]  SLOT_BCST = 4'h8;

    localparam logic [31:0] CNT_RESET     = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX       = 32'hFFFF_FFFF;
    localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
    localparam logic [31:0] TEST_LOAD_CNT = 32'h7FFF_FFFC;
    localparam logic [31:0] TEST_LOAD_BYT = 32'h7FFF_FF80;

    // ------------------------------------------------------------------
    // Frame lengths
    // ------------------------------------------------------------------
    localparam int          LEN_W       = 16;
    localparam logic [15:0] LEN_MIN     = 16'h0040;
    localparam logic [15:0] LEN_B65     = 16'h0041;
    localparam logic [15:0] LEN_B128    = 16'h0080;
    localparam logic [15:0] LEN_B256    = 16'h0100;
    localparam logic [15:0] LEN_B512    = 16'h0200;
    localparam logic [15:0] LEN_B1024   = 16'h0400;
    localparam logic [15:0] LEN_PAD_MAX = 16'h003C;
    localparam logic [15:0] LEN_FCS     = 16'h0004;

    // One report from the transmit MAC per finished attempt.
    typedef struct packed {
        logic             valid;
        logic [LEN_W-1:0] len;
        logic             bcast;
        logic             coll;
    } ptsc_tx_rpt_t;

endpackage

// ---- verilog/ptsc_port_tx_stats.sv ----
// Transmit statistics counter set for one switch port.
// Assumes the transmit MAC runs on core_clk_in and reports each attempt
// with a one-cycle valid; the register read port is driven by management
// logic on the same clock, so no input is synchronised.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Count frames of exactly 64 bytes.
// - Count frames of 65 to 127 bytes.
// - Count frames of 128 to 255 bytes.
// - Count frames of 256 to 511 bytes.
// - Count frames of 512 to 1023 bytes.
// - Count frames from 1024 to port maximum.
// - Count runts below 64; never bin them.
// - Unpadded tag-stripped short frames count as runts.
// - Add sent bytes, pause included, collisions excluded.
// - Count broadcast frames sent.
// - Reading returns value then clears counter.
// - Counters stick at all-ones until read.
// - Counters are 32 bits, reset to zero.
// - One set per port at its base.
// - Test mode reads load preset values instead.
// - Padding lifts short frames to at least minimum size.
module ptsc_port_tx_stats
    import ptsc_pkg::*;
#(
    // Register number of this port's first counter.
    parameter logic [11:0]      PORT_BASE     = BASE_PORT0,
    // Longest frame the port may send; longer frames reach no size bin.
    parameter logic [LEN_W-1:0] MAX_FRAME_LEN = 16'h05EE
) (
    // Clock, reset and clock enable.
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    input  wire logic         ce_in,
    // Configuration bits held in the neighbouring MAC control registers.
    input  wire logic         tx_pad_enable_in,
    input  wire logic         counter_read_test_mode_in,
    // Frame reports from the transmit MAC.
    input  wire ptsc_tx_rpt_t tx_rpt_in,
    // Register read port.
    input  wire logic         rd_strobe_in,
    input  wire logic [11:0]  rd_index_in,
    output logic              rd_valid_out,
    output logic              rd_hit_out,
    output logic [31:0]       rd_data_out
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Saturating add; a sum past all-ones sticks at all-ones.
    function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[32] ? CNT_MAX : sum[31:0];
    endfunction

    // Length on the wire after optional padding and FCS insertion.
    function automatic logic [LEN_W-1:0] wire_len(input logic [LEN_W-1:0] len,
                                                   input logic pad);
        logic [LEN_W-1:0] res;
        // Without padding the length passes through untouched.
        res = len;
        if (pad && (len < LEN_MIN)) begin
            // Up to 60 bytes grows to 64; 61 to 63 only gain the FCS.
            res = (len <= LEN_PAD_MAX) ? LEN_MIN : LEN_W'(len + LEN_FCS);
        end
        return res;
    endfunction

    // Maps an offset from the port base onto a counter slot.
    function automatic logic [4:0] map_slot(input logic [11:0] rel);
        logic [4:0] res;
        // Bit 4 flags a hit; the low bits name the slot.
        res = 5'h00;
        case (rel)
            REL_TX_EXACT_MIN:  res = {1'b1, SLOT_64};
            REL_TX_SMALL_BIN:  res = {1'b1, SLOT_65};
            REL_TX_MED_SMALL:  res = {1'b1, SLOT_128};
            REL_TX_MEDIUM:     res = {1'b1, SLOT_256};
            REL_TX_MED_LARGE:  res = {1'b1, SLOT_512};
            REL_TX_LARGE_BIN:  res = {1'b1, SLOT_1024};
            REL_TX_RUNT:       res = {1'b1, SLOT_RUNT};
            REL_TX_BYTE_TOTAL: res = {1'b1, SLOT_BYTE};
            REL_TX_BROADCAST:  res = {1'b1, SLOT_BCST};
            default:           res = 5'h00;
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------------

    // Nine words are few enough to keep in flip-flops.
    // Counter storage, one word per slot.
    logic [31:0]      cnt_reg  [NUM_CNT];
    // Next value of each counter.
    logic [31:0]      cnt_next [NUM_CNT];
    // Amount added to each counter this cycle.
    logic [31:0]      inc_amt  [NUM_CNT];
    // A completed, uncollided frame is reported this cycle.
    wire              frame_ok;
    // Length as it went out on the wire.
    wire [LEN_W-1:0]  eff_len;
    // One flag per counter slot, byte total and broadcast included.
    wire [NUM_CNT-1:0] bin_hit;

    // Collided attempts carry no completed frame, so they count nowhere.
    assign frame_ok = tx_rpt_in.valid && !tx_rpt_in.coll;
    assign eff_len  = wire_len(tx_rpt_in.len, tx_pad_enable_in);

    // A short frame sent unpadded (for example after a tag was stripped)
    // keeps its short length and lands in the runt counter, not in any size bin.
    assign bin_hit[SLOT_RUNT] = frame_ok && (eff_len < LEN_MIN);
    assign bin_hit[SLOT_64]   = frame_ok && (eff_len == LEN_MIN);
    assign bin_hit[SLOT_65]   = frame_ok && (eff_len >= LEN_B65) && (eff_len < LEN_B128);
    assign bin_hit[SLOT_128]  = frame_ok && (eff_len >= LEN_B128) && (eff_len < LEN_B256);
    assign bin_hit[SLOT_256]  = frame_ok && (eff_len >= LEN_B256) && (eff_len < LEN_B512);
    assign bin_hit[SLOT_512]  = frame_ok && (eff_len >= LEN_B512) && (eff_len < LEN_B1024);
    // Frames beyond the port maximum are not binned; the MAC should not
    // send them, and counting them as large would hide the fault.
    assign bin_hit[SLOT_1024] = frame_ok && (eff_len >= LEN_B1024)
                                && (eff_len <= MAX_FRAME_LEN);
    assign bin_hit[SLOT_BCST] = frame_ok && tx_rpt_in.bcast;
    // Every completed frame adds to the byte total, pause frames too.
    assign bin_hit[SLOT_BYTE] = frame_ok;

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------

    // Register number relative to this port's base.
    wire [11:0]        rd_rel;
    // Hit flag and slot of the addressed counter.
    wire [4:0]         rd_map;
    wire               rd_hit;
    wire [3:0]         rd_slot;
    // One clearing flag per counter.
    logic [NUM_CNT-1:0] rd_clear;

    // Numbers below the base wrap to a large offset and miss the map.
    assign rd_rel  = rd_index_in - PORT_BASE;
    assign rd_map  = map_slot(rd_rel);
    assign rd_hit  = rd_strobe_in && rd_map[4];
    assign rd_slot = rd_map[3:0];

    // ------------------------------------------------------------------
    // Counter update
    // ------------------------------------------------------------------

    // Works out each counter's next value. A read first restarts the word
    // from its load value and the increment of the same cycle is then added,
    // so an event that coincides with the read is never dropped.
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            rd_clear[i] = rd_hit && (rd_slot == 4'(i));
            // The byte total adds the wire length; every other slot adds one.
            if (i == int'(SLOT_BYTE)) begin
                inc_amt[i] = bin_hit[i] ? 32'(eff_len) : CNT_RESET;
            end else begin
                inc_amt[i] = bin_hit[i] ? CNT_ONE : CNT_RESET;
            end
            if (rd_clear[i] && counter_read_test_mode_in) begin
                // The byte total gets a lower preset, yet it still reaches 8000_0000 after two 64-byte
                // frames, sooner than the event counters, which need four events in a test run.
                cnt_next[i] = sat_add((i == int'(SLOT_BYTE)) ? TEST_LOAD_BYT
                                                             : TEST_LOAD_CNT,
                                      inc_amt[i]);
            end else if (rd_clear[i]) begin
                cnt_next[i] = inc_amt[i];
            end else begin
                cnt_next[i] = sat_add(cnt_reg[i], inc_amt[i]);
            end
        end
    end

    // Counter registers, cleared by reset and frozen while ce_in is low.
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < NUM_CNT; i++) begin
            // Reset acts whatever the enable, so a frozen block starts clean.
            if (rst_in) begin
                cnt_reg[i] <= CNT_RESET;
            end else if (ce_in) begin
                cnt_reg[i] <= cnt_next[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------

    // Captures the pre-clear value in the same edge that clears it, so
    // software always sees the value accumulated up to its read.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_hit_out   <= 1'b0;
            rd_data_out  <= CNT_RESET;
        end else if (ce_in) begin
            // Every strobe taken while ce_in is high is answered one cycle later, mapped or not.
            rd_valid_out <= rd_strobe_in;
            rd_hit_out   <= rd_hit;
            // Unmapped numbers, including the hole in the map, read zero.
            rd_data_out  <= rd_hit ? cnt_reg[rd_slot] : CNT_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    // All checks run on the system clock; all but chk_reset_zero rest while reset is high.
    // Checks that index by rd_slot rely on rd_hit to keep it in range.
    default clocking chk_clk @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // A 64-byte frame raises its bin by exactly one.
    chk_bin64_step: assert property (
        ce_in && bin_hit[SLOT_64] && !rd_clear[SLOT_64] && (cnt_reg[SLOT_64] != CNT_MAX)
        |=> cnt_reg[SLOT_64] == $past(cnt_reg[SLOT_64]) + CNT_ONE)
        else $error("64-byte bin did not step by one");

    // A 65-byte frame steps the 65 to 127 bin and leaves the 64 bin alone.
    chk_bin65_step: assert property (
        ce_in && frame_ok && (eff_len == LEN_B65) && !rd_hit
        && (cnt_reg[SLOT_65] != CNT_MAX)
        |=> (cnt_reg[SLOT_65] == $past(cnt_reg[SLOT_65]) + CNT_ONE)
            && (cnt_reg[SLOT_64] == $past(cnt_reg[SLOT_64])))
        else $error("65-127 bin wrong for a 65-byte frame");

    // Exactly one size or runt counter is chosen for an in-range frame.
    chk_bins_onehot: assert property (
        frame_ok && (eff_len <= MAX_FRAME_LEN)
        |-> $onehot({bin_hit[SLOT_RUNT], bin_hit[SLOT_64], bin_hit[SLOT_65],
                     bin_hit[SLOT_128], bin_hit[SLOT_256], bin_hit[SLOT_512],
                     bin_hit[SLOT_1024]}))
        else $error("frame not sorted into exactly one bin");

    // Edges of the middle bins fall on the documented limits.
    chk_bin_edges: assert property (
        frame_ok
        |-> ((eff_len != LEN_B256) || (bin_hit[SLOT_256] && !bin_hit[SLOT_128]))
            && ((eff_len != LEN_B512 - 16'h0001) || bin_hit[SLOT_256])
            && ((eff_len != LEN_B1024 - 16'h0001) || bin_hit[SLOT_512]))
        else $error("size bin boundary misplaced");

    // Without padding a short frame is a runt and no bin moves.
    chk_runt_only: assert property (
        ce_in && frame_ok && !tx_pad_enable_in && (tx_rpt_in.len < LEN_MIN) && !rd_hit
        |=> (cnt_reg[SLOT_64] == $past(cnt_reg[SLOT_64]))
            && (cnt_reg[SLOT_65] == $past(cnt_reg[SLOT_65]))
            && ((cnt_reg[SLOT_RUNT] == $past(cnt_reg[SLOT_RUNT]) + CNT_ONE)
                || ($past(cnt_reg[SLOT_RUNT]) == CNT_MAX)))
        else $error("unpadded short frame not counted as runt only");

    // With padding no frame can reach the runt counter.
    chk_pad_lifts: assert property (
        tx_pad_enable_in && frame_ok |-> !bin_hit[SLOT_RUNT] && (eff_len >= LEN_MIN))
        else $error("padded frame still short");

    // Byte total grows by the wire length; collided attempts add nothing.
    chk_byte_total: assert property (
        ce_in && tx_rpt_in.valid && !rd_clear[SLOT_BYTE]
        && (cnt_reg[SLOT_BYTE] < LEN_B1024)
        |=> cnt_reg[SLOT_BYTE] == $past(cnt_reg[SLOT_BYTE])
            + ($past(tx_rpt_in.coll) ? CNT_RESET : 32'($past(eff_len))))
        else $error("byte total added a wrong amount");

    // A broadcast frame steps the broadcast counter.
    chk_bcast_step: assert property (
        ce_in && frame_ok && tx_rpt_in.bcast && !rd_clear[SLOT_BCST]
        && (cnt_reg[SLOT_BCST] != CNT_MAX)
        |=> cnt_reg[SLOT_BCST] == $past(cnt_reg[SLOT_BCST]) + CNT_ONE)
        else $error("broadcast counter missed a frame");

    // A read answers the old value and leaves only this cycle's increment.
    chk_read_clear: assert property (
        ce_in && rd_hit && !counter_read_test_mode_in
        |=> rd_valid_out && rd_hit_out
            && (rd_data_out == $past(cnt_reg[rd_slot]))
            && (cnt_reg[$past(rd_slot)] == $past(inc_amt[rd_slot])))
        else $error("clearing read returned or left a wrong value");

    // A saturated counter stays at all-ones until it is read.
    chk_sat_hold: assert property (
        ce_in && (cnt_reg[SLOT_64] == CNT_MAX) && !rd_clear[SLOT_64]
        |=> cnt_reg[SLOT_64] == CNT_MAX)
        else $error("saturated counter moved without a read");

    // Reset leaves every counter at zero.
    chk_reset_zero: assert property (@(posedge core_clk_in) disable iff (1'b0)
        rst_in |=> (cnt_reg[SLOT_BYTE] == CNT_RESET) && (cnt_reg[SLOT_RUNT] == CNT_RESET)
                   && !rd_valid_out)
        else $error("counter not zero after reset");

    // Test mode loads the presets on a read of a quiet counter.
    chk_test_load: assert property (
        ce_in && rd_hit && counter_read_test_mode_in && (inc_amt[rd_slot] == CNT_RESET)
        |=> cnt_reg[$past(rd_slot)] == (($past(rd_slot) == SLOT_BYTE) ? TEST_LOAD_BYT
                                                                      : TEST_LOAD_CNT))
        else $error("test mode read loaded a wrong preset");

    // A read of the 64-byte bin that meets an increment restarts it at one.
    chk_read_inc: assert property (
        ce_in && rd_clear[SLOT_64] && bin_hit[SLOT_64] && !counter_read_test_mode_in
        |=> cnt_reg[SLOT_64] == CNT_ONE)
        else $error("increment lost under a clearing read");

    // Oversize frames reach no size bin but still add their bytes.
    chk_oversize_skip: assert property (
        frame_ok && (eff_len > MAX_FRAME_LEN)
        |-> !bin_hit[SLOT_1024] && !bin_hit[SLOT_512] && bin_hit[SLOT_BYTE])
        else $error("oversize frame binned or bytes dropped");

    // A number outside this port's map answers zero and clears nothing.
    chk_unmapped_read: assert property (
        ce_in && rd_strobe_in && !rd_hit
        |=> rd_valid_out && !rd_hit_out && (rd_data_out == CNT_RESET))
        else $error("unmapped read answered a counter");

    // A frozen cycle keeps the counters and the read answer as they are.
    chk_ce_freeze: assert property (
        !ce_in
        |=> (rd_valid_out == $past(rd_valid_out))
            && (cnt_reg[SLOT_64] == $past(cnt_reg[SLOT_64])))
        else $error("state moved while the clock enable was low");

    // A collided attempt moves neither a size bin nor the broadcast count.
    chk_coll_ignored: assert property (
        ce_in && tx_rpt_in.valid && tx_rpt_in.coll && !rd_hit
        |=> (cnt_reg[SLOT_64] == $past(cnt_reg[SLOT_64]))
            && (cnt_reg[SLOT_BCST] == $past(cnt_reg[SLOT_BCST])))
        else $error("collided attempt was counted");

    // Main scenarios worth seeing in simulation.
    cov_runt_frame:  cover property (ce_in && bin_hit[SLOT_RUNT]);
    cov_large_frame: cover property (ce_in && bin_hit[SLOT_1024]);
    cov_test_read:   cover property (ce_in && rd_hit && counter_read_test_mode_in);
    cov_read_inc:    cover property (ce_in && (rd_clear & bin_hit) != '0);
    cov_saturated:   cover property (cnt_reg[SLOT_BYTE] == CNT_MAX);

endmodule

`default_nettype wire

// ---- sim/ptsc_tx_mac_model.sv ----
// Behavioural transmit MAC that reports finished attempts to the counters.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module ptsc_tx_mac_model
    import ptsc_pkg::*;
(
    // Clock and report output.
    input  wire logic        core_clk_in,
    output var ptsc_tx_rpt_t tx_rpt_out
);
    initial tx_rpt_out = '0;

    // One report per call, valid for exactly one cycle.
    // Idle fields are inverted so a stale length never looks valid.
    task automatic send(input logic [15:0] len, input logic bc, input logic coll);
        @(negedge core_clk_in);
        tx_rpt_out = '{valid: 1'b1, len: len, bcast: bc, coll: coll};
        @(negedge core_clk_in);
        tx_rpt_out = '{valid: 1'b0, len: ~len, bcast: ~bc, coll: ~coll};
    endtask
endmodule
`default_nettype wire

// ---- sim/ptsc_port_tx_stats_tb_top.sv ----
// Self-checking bench for one port's transmit statistics counters.
// Assumes the design and a behavioural MAC share one 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ptsc_port_tx_stats_tb_top
    import ptsc_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic         clk = 1'b0;     // System clock.
    logic         rst = 1'b1;     // Synchronous reset.
    logic         ce = 1'b1;      // Clock enable.
    logic         pad = 1'b0;     // Transmit padding enable.
    logic         tm = 1'b0;      // Counter read test mode.
    logic         strobe = 1'b0;  // Read request.
    logic [11:0]  index = '0;     // Read register number.
    logic         rd_valid;
    logic         rd_hit;
    logic [31:0]  rd_data;
    ptsc_tx_rpt_t rpt;
    logic [31:0]  exp_cnt [9];    // Expected counters, by slot.
    int           n_fail = 0;
    int           n_tests = 0;
    int           cyc = 0;

    always #2 clk = ~clk;

    ptsc_tx_mac_model mac (.core_clk_in(clk), .tx_rpt_out(rpt));

    // Port 1 instance, so a port 0 number must miss.
    ptsc_port_tx_stats #(.PORT_BASE(BASE_PORT1)) dut (
        .core_clk_in(clk), .rst_in(rst), .ce_in(ce), .tx_pad_enable_in(pad),
        .counter_read_test_mode_in(tm), .tx_rpt_in(rpt), .rd_strobe_in(strobe),
        .rd_index_in(index), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
        .rd_data_out(rd_data));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Register number of a slot; the gap at offset 7 is unmapped.
    function automatic logic [11:0] idx(input int s);
        return BASE_PORT1 + 12'(s < 7 ? s : s + 1);
    endfunction

    // One read; the answer stands in the cycle after the strobe edge.
    task automatic rd(input logic [11:0] ix, input logic hit, input logic [31:0] d);
        @(negedge clk);
        strobe = 1'b1;
        index = ix;
        @(negedge clk);
        strobe = 1'b0;
        index = ~ix;
        `CHK("rd_valid_out", 1'b1, rd_valid)
        `CHK("rd_hit_out", hit, rd_hit)
        `CHK("rd_data_out", d, rd_data)
    endtask

    // Send a frame and work out what it should add, after padding.
    task automatic fr(input logic [15:0] len, input logic bc, input logic coll);
        logic [15:0] e;
        mac.send(len, bc, coll);
        e = len;
        if (pad && len <= 16'h003C) e = 16'h0040;
        else if (pad && len < 16'h0040) e = len + 16'h0004;
        if (coll) return;
        exp_cnt[7] += 32'(e);
        if (bc) exp_cnt[8]++;
        if (e < 16'h0040) exp_cnt[6]++;
        else if (e == 16'h0040) exp_cnt[0]++;
        else if (e < 16'h0080) exp_cnt[1]++;
        else if (e < 16'h0100) exp_cnt[2]++;
        else if (e < 16'h0200) exp_cnt[3]++;
        else if (e < 16'h0400) exp_cnt[4]++;
        else if (e <= 16'h05EE) exp_cnt[5]++;
    endtask

    // Read every counter, then expect it cleared or preset.
    task automatic chk_all(input logic t);
        for (int s = 0; s < 9; s++) begin
            rd(idx(s), 1'b1, exp_cnt[s]);
            exp_cnt[s] = !t ? CNT_RESET : (s == 7 ? TEST_LOAD_BYT : TEST_LOAD_CNT);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_all(1'b0);
        rd(12'h045B + BASE_PORT1 - BASE_PORT0, 1'b0, CNT_RESET);
        rd(REG_TX_EXACT_MIN, 1'b0, CNT_RESET);
    endtask

    // Every bin edge, a runt with padding off, an oversize and a collision.
    task automatic t_bins();
        logic [15:0] lens [13] = '{16'h003F, 16'h0040, 16'h0041, 16'h007F,
            16'h0080, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h03FF,
            16'h0400, 16'h05EE, 16'h05EF};
        for (int i = 0; i < 13; i++) fr(lens[i], 1'(i % 2), 1'b0);
        fr(16'h0040, 1'b1, 1'b1);
        chk_all(1'b0);
        chk_all(1'b0);
    endtask

    task automatic t_pad();
        pad = 1'b1;
        fr(16'h003C, 1'b0, 1'b0);
        fr(16'h003E, 1'b1, 1'b0);
        chk_all(1'b0);
        pad = 1'b0;
    endtask

    task automatic t_test_mode();
        tm = 1'b1;
        fr(16'h0040, 1'b1, 1'b0);
        chk_all(1'b1);
        tm = 1'b0;
        chk_all(1'b0);
    endtask

    // Increment and clearing read meet at one edge; the increment survives.
    task automatic t_race();
        fork
            mac.send(16'h0040, 1'b0, 1'b0);
            rd(idx(0), 1'b1, CNT_RESET);
        join
        exp_cnt[0] = CNT_ONE;
        exp_cnt[7] = 32'h0000_0040;
        chk_all(1'b0);
    endtask

    // A strobe while the enable is low must neither answer nor clear.
    task automatic t_ce_hold();
        fr(16'h0040, 1'b0, 1'b0);
        @(negedge clk);
        ce = 1'b0;
        strobe = 1'b1;
        index = idx(0);
        @(negedge clk);
        ce = 1'b1;
        strobe = 1'b0;
        `CHK("rd_valid_out", 1'b0, rd_valid)
        chk_all(1'b0);
    endtask

    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // A hang is cut short well beyond the roughly 190 cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        foreach (exp_cnt[s]) exp_cnt[s] = CNT_RESET;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_bins();
        t_pad();
        t_test_mode();
        t_race();
        t_ce_hold();
        complete_run();
    end
endmodule
`default_nettype wire
